/* File: logic/adq_sequencer.sv */
// Converter sequencer top: AXI4-Lite registers, modes, hold, injection, calibration.
// Assumes a 10 MHz aclk and an analog core behind adq_conv_core.
// Summary of operation
// - Sixteen channels, ten-bit result, one sampler
// - Overrun signalling: interrupt when result still unread
// - Overrun protection: next conversion waits for read
// - Single channel single: convert once, then stop
// - Single channel continuous: repeat, store every value
// - Scan single: each set channel once, store each
// - Scan continuous: cycle the set forever
// - Every result raises interrupt or transfer request
// - Wait-for-read, continuous modes only: park value, pause until read
// - Injected conversion goes to injected result register
// - After injection, continuous mode resumes unchanged
// - Conversion lasts 14 conv_clock_period, 2 sample_clock_period, 4 units
// - Reset calibration 1.25 ms, busy flag set
// - Conversions during calibration extend its length
// - Calibration of 4 conv_clock_period after every conversion
// - Clock codes 00/10/11 give 24/96/48 units
// - Sample clock is 1, 2, 4, 8 conv_clock_period
// - Unused channel pins readable as digital inputs
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adq_sequencer
	import adq_pkg::*;
#(
	parameter int CAL_CYCLES = ADQ_CAL_CYC
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [ADQ_CH_W-1:0] ana_sel,
	output logic ana_sample,
	input wire logic [ADQ_RES_W-1:0] ana_data,
	input wire logic [15:0] dig_pin,
	output logic etc_req,
	output logic [ADQ_RES_W-1:0] etc_data,
	input wire logic etc_ack,
	output logic irq
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic aw_ok;
		logic [7:0] aw_addr;
		logic w_ok;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [ADQ_RES_W-1:0] res;
		logic [ADQ_CH_W-1:0] res_ch;
		logic unread;
		logic [ADQ_RES_W-1:0] hbuf;
		logic [ADQ_CH_W-1:0] hbuf_ch;
		logic held;
		logic [ADQ_RES_W-1:0] inj_res;
		logic [ADQ_CH_W-1:0] inj_ch;
		logic inj_pend;
		logic inj_run;
		logic run;
		logic [ADQ_CH_W-1:0] cur_ch;
		logic [ADQ_CAL_W-1:0] cal_cnt;
		logic cal_act;
		logic [2:0] istat;
		logic [2:0] imask;
		logic req;
	} adq_seq_t;

	adq_seq_t r_reg, r_next;
	adq_conv_if cif();
	adq_mode_t mode;
	logic cont, prot, wren, busy, start_conv, do_wr, rd_res, consume;
	logic [ADQ_CH_W-1:0] cfg_ch;
	logic [2:0] iset, iclr;
	logic [15:0] used;

	function automatic logic [31:0] adq_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			adq_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction: adq_merge

	function automatic logic [15:0] adq_used(input adq_mode_t m, input logic [3:0] ch);
		for (int i = 0; i < 16; i++)
			adq_used[i] = (m == ADQ_M_SGL || m == ADQ_M_CONT) ? (i == int'(ch)) : (i <= int'(ch));
	endfunction: adq_used

	adq_conv_core u_core (
		.aclk(aclk),
		.aresetn(aresetn),
		.cif(cif.core),
		.ana_sel(ana_sel),
		.ana_sample(ana_sample),
		.ana_data(ana_data)
	);

	assign mode = adq_mode_t'(r_reg.ctrl[ADQ_F_MODE +: 2]);
	assign cont = mode == ADQ_M_CONT || mode == ADQ_M_SCANC;
	assign prot = r_reg.ctrl[ADQ_F_PROT];
	assign wren = r_reg.ctrl[ADQ_F_WREN];
	assign cfg_ch = r_reg.ctrl[ADQ_F_CHAN +: ADQ_CH_W];
	assign busy = r_reg.cal_act | ~cif.ready;
	assign used = adq_used(mode, cfg_ch);
	// Held value or unread result under protection blocks the sequence
	assign start_conv = cif.ready && !r_reg.held
		&& (r_reg.inj_pend || (r_reg.run && !(prot && r_reg.unread)));
	assign cif.start = start_conv;
	assign cif.chan = r_reg.inj_pend ? r_reg.inj_ch : r_reg.cur_ch;
	assign cif.ctc = r_reg.ctrl[ADQ_F_CTC +: 2];
	assign cif.stc = r_reg.ctrl[ADQ_F_STC +: 2];
	assign do_wr = r_reg.aw_ok && r_reg.w_ok;
	assign rd_res = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADQ_OFF_RES;
	assign consume = rd_res || etc_ack;

	always_comb
	begin
		r_next = r_reg;
		r_next.req = 1'b0;
		iset = 3'h0;
		iclr = 3'h0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			r_next.aw_ok = 1'b1;
			r_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			r_next.w_ok = 1'b1;
			r_next.w_data = s_axi_wdata;
			r_next.w_strb = s_axi_wstrb;
		end
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;
		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			r_next.rvalid = 1'b1;
			r_next.rresp = ADQ_OKAY;
			case (s_axi_araddr)
				ADQ_OFF_CTRL: r_next.rdata = r_reg.ctrl;
				ADQ_OFF_RES: r_next.rdata = {16'h0000, r_reg.res_ch, 2'h0, r_reg.res};
				ADQ_OFF_INJ: r_next.rdata = {16'h0000, r_reg.inj_ch, 2'h0, r_reg.inj_res};
				ADQ_OFF_STAT: r_next.rdata = {27'h0, r_reg.inj_pend, r_reg.held,
					r_reg.unread, r_reg.cal_act, busy};
				ADQ_OFF_ISTAT: r_next.rdata = {29'h0, r_reg.istat};
				ADQ_OFF_IMASK: r_next.rdata = {29'h0, r_reg.imask};
				ADQ_OFF_DIG: r_next.rdata = {16'h0000, dig_pin & ~used};
				default:
				begin
					r_next.rdata = 32'h0000_0000;
					r_next.rresp = ADQ_SLVERR;
				end
			endcase
		end

		// Release parked value first so a read never loses it
		if (consume)
		begin
			if (r_reg.held)
			begin
				r_next.res = r_reg.hbuf;
				r_next.res_ch = r_reg.hbuf_ch;
				r_next.held = 1'b0;
				r_next.req = 1'b1;
				iset[ADQ_I_DONE] = 1'b1;
			end
			else
				r_next.unread = 1'b0;
		end

		if (cif.done)
		begin
			if (r_reg.inj_run)
			begin
				r_next.inj_res = cif.result;
				r_next.inj_run = 1'b0;
				iset[ADQ_I_INJ] = 1'b1;
			end
			else
			begin
				if (r_next.unread && wren && cont)
				begin
					r_next.hbuf = cif.result;
					r_next.hbuf_ch = cif.res_ch;
					r_next.held = 1'b1;
				end
				else
				begin
					if (r_next.unread && !prot)
						iset[ADQ_I_OVR] = 1'b1;
					r_next.res = cif.result;
					r_next.res_ch = cif.res_ch;
					r_next.unread = 1'b1;
					r_next.req = 1'b1;
					iset[ADQ_I_DONE] = 1'b1;
				end
				case (mode)
					ADQ_M_SGL: r_next.run = 1'b0;
					ADQ_M_CONT: r_next.run = r_reg.run;
					ADQ_M_SCAN, ADQ_M_SCANC:
						if (r_reg.cur_ch == '0)
						begin
							r_next.cur_ch = cfg_ch;
							r_next.run = mode == ADQ_M_SCANC;
						end
						else
							r_next.cur_ch = r_reg.cur_ch - 1'b1;
					default: r_next.run = 1'b0;
				endcase
			end
		end

		// Injection borrows one slot and leaves the mode untouched
		if (start_conv && r_reg.inj_pend)
		begin
			r_next.inj_pend = 1'b0;
			r_next.inj_run = 1'b1;
		end

		if (r_reg.cal_act && cif.ready)
		begin
			if (r_reg.cal_cnt == '0)
				r_next.cal_act = 1'b0;
			else
				r_next.cal_cnt = r_reg.cal_cnt - 1'b1;
		end

		if (do_wr)
		begin
			r_next.aw_ok = 1'b0;
			r_next.w_ok = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = ADQ_OKAY;
			case (r_reg.aw_addr)
				ADQ_OFF_CTRL:
				begin
					r_next.ctrl = adq_merge(r_reg.ctrl, r_reg.w_data, r_reg.w_strb);
					// Command bits act once and read back as zero
					r_next.ctrl[ADQ_F_START] = 1'b0;
					r_next.ctrl[ADQ_F_STOP] = 1'b0;
					r_next.ctrl[ADQ_F_INJ] = 1'b0;
					if (r_reg.w_strb[0] && r_reg.w_data[ADQ_F_STOP])
					begin
						r_next.run = 1'b0;
						r_next.inj_pend = 1'b0;
					end
					else if (r_reg.w_strb[0] && r_reg.w_data[ADQ_F_START])
					begin
						r_next.run = 1'b1;
						r_next.cur_ch = r_next.ctrl[ADQ_F_CHAN +: ADQ_CH_W];
					end
					if (r_reg.w_strb[1] && r_reg.w_data[ADQ_F_INJ] && r_reg.run && cont)
					begin
						r_next.inj_pend = 1'b1;
						r_next.inj_ch = r_next.ctrl[ADQ_F_ICH +: ADQ_CH_W];
					end
				end
				ADQ_OFF_ISTAT:
					if (r_reg.w_strb[0])
						iclr = r_reg.w_data[2:0];
				ADQ_OFF_IMASK:
					if (r_reg.w_strb[0])
						r_next.imask = r_reg.w_data[2:0];
				ADQ_OFF_RES, ADQ_OFF_INJ, ADQ_OFF_STAT, ADQ_OFF_DIG: ;
				default: r_next.bresp = ADQ_SLVERR;
			endcase
		end
		// Set beats clear in the same cycle
		r_next.istat = (r_reg.istat & ~iclr) | iset;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r_reg <= '0;
			r_reg.ctrl <= ADQ_CTRL_RST;
			r_reg.cal_act <= 1'b1;
			r_reg.cal_cnt <= ADQ_CAL_W'(CAL_CYCLES - 1);
		end
		else
			r_reg <= r_next;
	end

	assign s_axi_awready = !r_reg.aw_ok && !r_reg.bvalid;
	assign s_axi_wready = !r_reg.w_ok && !r_reg.bvalid;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_arready = !r_reg.rvalid;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign etc_req = r_reg.req;
	assign etc_data = r_reg.res;
	assign irq = |(r_reg.istat & r_reg.imask);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_busy_cal;
		r_reg.cal_act |-> busy;
	endproperty
	a_busy_cal: assert property (p_busy_cal) else $error("busy low in calibration");
	property p_cal_hold;
		r_reg.cal_act && !cif.ready |=> r_reg.cal_cnt == $past(r_reg.cal_cnt);
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("calibration ran during conversion");
	property p_ovr;
		cif.done && !r_reg.inj_run && r_reg.unread && !consume && !prot && !(wren && cont)
			|=> r_reg.istat[ADQ_I_OVR];
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun not flagged");
	property p_prot;
		prot && r_reg.unread && !r_reg.inj_pend |-> !start_conv;
	endproperty
	a_prot: assert property (p_prot) else $error("conversion started over unread result");
	property p_hold;
		r_reg.held |-> !start_conv ##1 (r_reg.held || r_reg.unread);
	endproperty
	a_hold: assert property (p_hold) else $error("held value lost or conversion started");
	property p_single;
		cif.done && !r_reg.inj_run && mode == ADQ_M_SGL && !do_wr |=> !r_reg.run;
	endproperty
	a_single: assert property (p_single) else $error("single conversion did not stop");
	property p_inj;
		cif.done && r_reg.inj_run |=> r_reg.inj_res == $past(cif.result)
			&& r_reg.res == $past(r_reg.res) && r_reg.istat[ADQ_I_INJ];
	endproperty
	a_inj: assert property (p_inj) else $error("injected result misplaced");
	property p_resume;
		cif.done && r_reg.inj_run && !do_wr |=> r_reg.run == $past(r_reg.run)
			&& r_reg.cur_ch == $past(r_reg.cur_ch);
	endproperty
	a_resume: assert property (p_resume) else $error("mode changed by injection");
	property p_read_clr;
		consume && !r_reg.held && !cif.done |=> !r_reg.unread;
	endproperty
	a_read_clr: assert property (p_read_clr) else $error("read left result unread");
	property p_req;
		cif.done && !r_reg.inj_run && !(r_next.held) |=> etc_req ##1 !etc_req;
	endproperty
	a_req: assert property (p_req) else $error("no request for result");
	c_scan_wrap: cover property (cif.done && mode == ADQ_M_SCANC && r_reg.cur_ch == '0);
	c_inject: cover property (cif.done && r_reg.inj_run && r_reg.run);
	c_held: cover property (r_reg.held && consume);
	c_cal_end: cover property ($fell(r_reg.cal_act));
endmodule: adq_sequencer

/* File: shared/adq_pkg.sv */
// Constants, field layout and timing for the converter sequencer.
// Assumes one 10 MHz clock; one base time unit equals one clock cycle.
package adq_pkg;
	localparam int ADQ_CH_W = 4;
	localparam int ADQ_RES_W = 10;
	localparam int ADQ_CNT_W = 12;
	localparam int ADQ_CAL_W = 24;
	localparam int ADQ_CLK_NS = 100;
	localparam int ADQ_CAL_NS = 1250000;
	// Least time, rounded up
	localparam int ADQ_CAL_CYC = (ADQ_CAL_NS + ADQ_CLK_NS - 1) / ADQ_CLK_NS;
	localparam logic [11:0] ADQ_TCC_00 = 12'h018;
	localparam logic [11:0] ADQ_TCC_10 = 12'h060;
	localparam logic [11:0] ADQ_TCC_11 = 12'h030;
	localparam logic [11:0] ADQ_SAMP_TSC = 12'h002;
	localparam logic [11:0] ADQ_CONV_TCC = 12'h00E;
	localparam logic [11:0] ADQ_XFER_TCL = 12'h004;
	localparam logic [11:0] ADQ_CALC_TCC = 12'h004;
	localparam logic [7:0] ADQ_OFF_CTRL = 8'h00;
	localparam logic [7:0] ADQ_OFF_RES = 8'h04;
	localparam logic [7:0] ADQ_OFF_INJ = 8'h08;
	localparam logic [7:0] ADQ_OFF_STAT = 8'h0C;
	localparam logic [7:0] ADQ_OFF_ISTAT = 8'h10;
	localparam logic [7:0] ADQ_OFF_IMASK = 8'h14;
	localparam logic [7:0] ADQ_OFF_DIG = 8'h18;
	localparam int ADQ_F_MODE = 0;
	localparam int ADQ_F_START = 2;
	localparam int ADQ_F_STOP = 3;
	localparam int ADQ_F_CHAN = 4;
	localparam int ADQ_F_PROT = 8;
	localparam int ADQ_F_WREN = 9;
	localparam int ADQ_F_CTC = 10;
	localparam int ADQ_F_STC = 12;
	localparam int ADQ_F_INJ = 14;
	localparam int ADQ_F_ICH = 16;
	localparam int ADQ_F_RCH = 12;
	localparam int ADQ_I_DONE = 0;
	localparam int ADQ_I_OVR = 1;
	localparam int ADQ_I_INJ = 2;
	localparam logic [31:0] ADQ_CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] ADQ_OKAY = 2'h0;
	localparam logic [1:0] ADQ_SLVERR = 2'h2;

	typedef enum logic [1:0] {ADQ_M_SGL, ADQ_M_CONT, ADQ_M_SCAN, ADQ_M_SCANC} adq_mode_t;

	// Reserved code 01 falls back to the fastest clock
	function automatic logic [11:0] adq_tcc(input logic [1:0] sel);
		case (sel)
			2'h2: adq_tcc = ADQ_TCC_10;
			2'h3: adq_tcc = ADQ_TCC_11;
			default: adq_tcc = ADQ_TCC_00;
		endcase
	endfunction: adq_tcc
endpackage: adq_pkg

/* File: shared/adq_conv_if.sv */
// Link between the sequencer and the conversion timing core.
// Assumes both ends share aclk.
`timescale 1ns/1ps
interface adq_conv_if;
	import adq_pkg::*;
	logic start;
	logic [ADQ_CH_W-1:0] chan;
	logic [1:0] ctc;
	logic [1:0] stc;
	logic ready;
	logic done;
	logic [ADQ_RES_W-1:0] result;
	logic [ADQ_CH_W-1:0] res_ch;
	modport ctrl(output start, chan, ctc, stc, input ready, done, result, res_ch);
	modport core(input start, chan, ctc, stc, output ready, done, result, res_ch);
endinterface: adq_conv_if

/* File: logic/adq_conv_core.sv */
// Timing core for one conversion: sample, convert, transfer, calibrate.
// Assumes the analog core presents a settled result while converting.
`timescale 1ns/1ps
module adq_conv_core
	import adq_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	adq_conv_if.core cif,
	output logic [ADQ_CH_W-1:0] ana_sel,
	output logic ana_sample,
	input wire logic [ADQ_RES_W-1:0] ana_data
);
	typedef enum logic [2:0] {ADQ_S_IDLE, ADQ_S_SAMP, ADQ_S_CONV, ADQ_S_XFER, ADQ_S_CAL} adq_cst_t;
	typedef struct packed {
		adq_cst_t st;
		logic [11:0] cnt;
		logic [ADQ_CH_W-1:0] ch;
		logic [1:0] ctc;
		logic [1:0] stc;
		logic [ADQ_RES_W-1:0] res;
		logic [11:0] len;
	} adq_core_t;
	adq_core_t r_reg, r_next;
	logic [11:0] conv_clock_period, sample_clock_period, tsc_in, exp_len;

	assign conv_clock_period = adq_tcc(r_reg.ctc);
	assign sample_clock_period = conv_clock_period << r_reg.stc;
	assign tsc_in = adq_tcc(cif.ctc) << cif.stc;
	assign exp_len = ADQ_SAMP_TSC * sample_clock_period + ADQ_CONV_TCC * conv_clock_period + ADQ_XFER_TCL;

	always_comb
	begin
		r_next = r_reg;
		r_next.len = r_reg.len + 12'h001;
		case (r_reg.st)
			ADQ_S_IDLE:
				if (cif.start)
				begin
					r_next.st = ADQ_S_SAMP;
					r_next.cnt = ADQ_SAMP_TSC * tsc_in - 12'h001;
					r_next.ch = cif.chan;
					r_next.ctc = cif.ctc;
					r_next.stc = cif.stc;
					r_next.len = 12'h001;
				end
			ADQ_S_SAMP:
				if (r_reg.cnt == 12'h000)
				begin
					r_next.st = ADQ_S_CONV;
					r_next.cnt = ADQ_CONV_TCC * conv_clock_period - 12'h001;
				end
				else
					r_next.cnt = r_reg.cnt - 12'h001;
			ADQ_S_CONV:
				if (r_reg.cnt == 12'h000)
				begin
					r_next.st = ADQ_S_XFER;
					r_next.cnt = ADQ_XFER_TCL - 12'h001;
					r_next.res = ana_data;
				end
				else
					r_next.cnt = r_reg.cnt - 12'h001;
			ADQ_S_XFER:
				if (r_reg.cnt == 12'h000)
				begin
					r_next.st = ADQ_S_CAL;
					r_next.cnt = ADQ_CALC_TCC * conv_clock_period - 12'h001;
				end
				else
					r_next.cnt = r_reg.cnt - 12'h001;
			ADQ_S_CAL:
				if (r_reg.cnt == 12'h000)
					r_next.st = ADQ_S_IDLE;
				else
					r_next.cnt = r_reg.cnt - 12'h001;
			default: r_next.st = ADQ_S_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r_reg <= '{st: ADQ_S_IDLE, default: '0};
		else
			r_reg <= r_next;
	end

	assign cif.ready = r_reg.st == ADQ_S_IDLE;
	assign cif.done = r_reg.st == ADQ_S_XFER && r_reg.cnt == 12'h000;
	assign cif.result = r_reg.res;
	assign cif.res_ch = r_reg.ch;
	assign ana_sel = r_reg.ch;
	assign ana_sample = r_reg.st == ADQ_S_SAMP;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_conv_len;
		cif.done |-> r_reg.len == exp_len;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
	property p_cal_cycle;
		cif.done |=> r_reg.st == ADQ_S_CAL && r_reg.cnt == ADQ_CALC_TCC * conv_clock_period - 12'h001
			##1 (!cif.ready)[*3];
	endproperty
	a_cal_cycle: assert property (p_cal_cycle) else $error("calibration cycle wrong");
	property p_tcc_map;
		!cif.ready |-> conv_clock_period == (r_reg.ctc == 2'h2 ? 12'h060 : r_reg.ctc == 2'h3 ? 12'h030 : 12'h018);
	endproperty
	a_tcc_map: assert property (p_tcc_map) else $error("conversion clock code wrong");
endmodule: adq_conv_core

/* File: test/adq_ana_model.sv */
// Behavioural analog mux and sample-and-hold core facing the sequencer.
// Assumes ana_sel is steady while ana_sample is high.
`timescale 1ns/1ps
module adq_ana_model
	import adq_pkg::*;
(
	input wire logic aclk,
	input wire logic [ADQ_CH_W-1:0] ana_sel,
	input wire logic ana_sample,
	output logic [ADQ_RES_W-1:0] ana_data
);
	logic [ADQ_CH_W-1:0] held_ch = 4'h0;
	logic [ADQ_RES_W-1:0] churn = 10'h155;
	always @(posedge aclk)
	begin
		churn <= ~churn;
		if (ana_sample)
			held_ch <= ana_sel;
	end
	// No settled level while sampling, so the line keeps toggling
	assign ana_data = ana_sample ? churn : {held_ch, 6'h2B};
endmodule: adq_ana_model

/* File: test/testbench.sv */
// Self-checking bench for the converter sequencer over AXI4-Lite.
// Assumes the analog model answers {channel, 6'h2B} after sampling.
`timescale 1ns/1ps
module testbench;
	import adq_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, etc_ack = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [ADQ_CH_W-1:0] ana_sel;
	logic ana_sample, etc_req, irq, last_s = 0, g;
	logic [ADQ_RES_W-1:0] ana_data, etc_data;
	logic [15:0] dig_pin = 16'h0000;
	logic [31:0] d;
	logic [1:0] r;
	int bad_count = 0, checks = 0, cyc = 0, rise_t = 0, samp_n = 0, req_n = 0, req_t = 0;
	int rel_t = 0;
	always #50 aclk = ~aclk;
	adq_sequencer #(.CAL_CYCLES(20)) adq_sequencer_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ana_sel, .ana_sample, .ana_data, .dig_pin, .etc_req, .etc_data,
		.etc_ack, .irq);
	adq_ana_model adq_ana_model_inst (.aclk, .ana_sel, .ana_sample, .ana_data);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask: complete_run
	// Sampling at the falling edge sees what the next rising edge will take
	always @(negedge aclk)
	begin
		cyc++;
		if (ana_sample)
			samp_n++;
		if (ana_sample && !last_s)
			rise_t = cyc;
		last_s = ana_sample;
		if (etc_req)
		begin
			req_n++;
			req_t = cyc;
		end
		if (cyc > 60000)
		begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask: chk
	task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
		logic pa, pw, ta, tw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		pa = 1;
		pw = 1;
		while (pa | pw)
		begin
			@(negedge aclk);
			ta = pa & s_axi_awready;
			tw = pw & s_axi_wready;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 0;
			if (tw)
				s_axi_wvalid <= 0;
			pa = pa & !ta;
			pw = pw & !tw;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 0;
	endtask: wr
	task automatic w(input logic [7:0] a, input logic [31:0] dat);
		logic [1:0] rs;
		wr(a, dat, rs);
	endtask: w
	task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 0;
		do @(negedge aclk); while (!s_axi_rvalid);
		dat = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 0;
	endtask: rd
	task automatic wait_req(input int lim, output logic got);
		int s, k;
		s = req_n;
		k = 0;
		while (req_n == s && k < lim)
		begin
			@(negedge aclk);
			k++;
		end
		#1 got = (req_n != s);
	endtask: wait_req
	// Stop lets a running conversion finish before flags are cleared
	task automatic halt;
		w(ADQ_OFF_CTRL, 32'h0000_0008);
		wait_req(1700, g);
		rd(ADQ_OFF_RES, d, r);
		w(ADQ_OFF_ISTAT, 32'h0000_0007);
	endtask: halt
	task automatic t_cal;
		rd(ADQ_OFF_STAT, d, r);
		chk(d[1:0], 2'h3);
		w(ADQ_OFF_CTRL, 32'h0000_0034);
		wait_req(2000, g);
		chk(g, 1'b1);
		do rd(ADQ_OFF_STAT, d, r); while (d[1] === 1'b1 && cyc < 5000);
		chk(d[1], 1'b0);
		chk(32'(cyc - rel_t >= 20 + 388), 32'h1);
		rd(ADQ_OFF_RES, d, r);
		$display("test cal done");
	endtask: t_cal
	task automatic t_conv;
		int ctc[3] = '{0, 2, 3};
		int stc[3] = '{1, 2, 3};
		int conv_clock_period[3] = '{24, 96, 48};
		int sample_clock_period;
		logic [3:0] ch;
		for (int i = 0; i < 3; i++)
		begin
			sample_clock_period = conv_clock_period[i] << stc[i];
			ch = 4'(4 + i);
			samp_n = 0;
			w(ADQ_OFF_CTRL, 32'h4 | (ch << 4) | (ctc[i] << 10) | (stc[i] << 12));
			wait_req(3000, g);
			chk(samp_n, 2 * sample_clock_period);
			chk(req_t - rise_t, 2 * sample_clock_period + 14 * conv_clock_period[i] + 4);
			chk(etc_data, {ch, 6'h2B});
			rd(ADQ_OFF_RES, d, r);
			chk(d[15:0], {ch, 2'b00, ch, 6'h2B});
			wait_req(2000, g);
			chk(g, 1'b0);
		end
		$display("test conv done");
	endtask: t_conv
	task automatic t_ovr;
		int t1;
		w(ADQ_OFF_IMASK, 32'h0000_0007);
		w(ADQ_OFF_CTRL, 32'h0000_0075);
		wait_req(1000, g);
		t1 = req_t;
		wait_req(1000, g);
		chk(32'(req_t - t1 >= 484 && req_t - t1 <= 486), 32'h1);
		rd(ADQ_OFF_ISTAT, d, r);
		chk(d[1:0], 2'h3);
		chk(irq, 1'b1);
		w(ADQ_OFF_IMASK, 32'h0000_0000);
		chk(irq, 1'b0);
		w(ADQ_OFF_IMASK, 32'h0000_0007);
		halt();
		rd(ADQ_OFF_ISTAT, d, r);
		chk(d[2:0], 3'h0);
		chk(irq, 1'b0);
		$display("test overrun done");
	endtask: t_ovr
	task automatic t_hold(input logic prot);
		w(ADQ_OFF_CTRL, prot ? 32'h0000_0125 : 32'h0000_0225);
		wait_req(1000, g);
		chk(g, 1'b1);
		wait_req(1500, g);
		chk(g, 1'b0);
		if (prot)
			rd(ADQ_OFF_RES, d, r);
		else
		begin
			rd(ADQ_OFF_STAT, d, r);
			chk(d[3], 1'b1);
			@(posedge aclk);
			etc_ack <= 1;
			@(posedge aclk);
			etc_ack <= 0;
		end
		wait_req(prot ? 700 : 5, g);
		chk(g, 1'b1);
		halt();
		$display("test hold done");
	endtask: t_hold
	task automatic t_scan;
		w(ADQ_OFF_CTRL, 32'h0000_0026);
		for (int k = 2; k >= 0; k--)
		begin
			wait_req(2000, g);
			rd(ADQ_OFF_RES, d, r);
			chk(d[15:12], 4'(k));
		end
		wait_req(1600, g);
		chk(g, 1'b0);
		$display("test scan done");
	endtask: t_scan
	task automatic t_inj;
		w(ADQ_OFF_CTRL, 32'h0000_0017);
		wait_req(1000, g);
		w(ADQ_OFF_CTRL, 32'h0009_4013);
		do rd(ADQ_OFF_ISTAT, d, r); while (d[2] !== 1'b1 && cyc < 50000);
		rd(ADQ_OFF_INJ, d, r);
		chk(d[15:0], 16'h9000 | 16'h0240 | 16'h002B);
		wait_req(1600, g);
		chk(g, 1'b1);
		rd(ADQ_OFF_RES, d, r);
		chk(32'(d[15:12] <= 4'h1), 32'h1);
		halt();
		$display("test inject done");
	endtask: t_inj
	task automatic t_misc;
		dig_pin <= 16'hFFFF;
		w(ADQ_OFF_CTRL, 32'h0000_0032);
		rd(ADQ_OFF_DIG, d, r);
		chk(d[15:0], 16'hFFF0);
		wr(8'h40, 32'h0000_0001, r);
		chk(r, ADQ_SLVERR);
		rd(8'h40, d, r);
		chk(r, ADQ_SLVERR);
		$display("test misc done");
	endtask: t_misc
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rel_t = cyc;
		t_cal();
		t_conv();
		t_ovr();
		t_hold(1'b1);
		t_hold(1'b0);
		t_scan();
		t_inj();
		t_misc();
		complete_run();
	end
endmodule: testbench
